/* File: hw/lesb_pkg.sv */
package lesb_pkg;

    // ------------------------------------------------------------------
    // register offsets (fieldbus parameter addresses)
    // ------------------------------------------------------------------
    localparam logic [15:0] LESB_OFS_STOP_CODE  = 16'h1c0a;
    localparam logic [15:0] LESB_OFS_SIG_LATCH  = 16'h1c10;
    localparam logic [15:0] LESB_OFS_LAST_CODE  = 16'h1c12;
    localparam logic [15:0] LESB_OFS_WARN_LATCH = 16'h1c18;

    // ------------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [15:0] LESB_RST_CODE  = 16'h0000;
    localparam logic [15:0] LESB_RST_WARN  = 16'h0000;
    localparam logic [31:0] LESB_RST_SIG   = 32'h0000_0000;
    // warning bits that fall by themselves: 10, 11, 13
    localparam logic [15:0] LESB_WARN_AUTO = 16'h2c00;
    // reserved warning bits: 3, 15
    localparam logic [15:0] LESB_WARN_RSVD = 16'h8008;
    // reserved signal bits: 5, 11, 13, 25, 26, 27, 28
    localparam logic [31:0] LESB_SIG_RSVD  = 32'h1e00_2820;
    // warning groups: bits 7..0 and 15..8
    localparam logic [15:0] LESB_WARN_GRP_LO = 16'h00ff;
    localparam logic [15:0] LESB_WARN_GRP_HI = 16'hff00;
    // signal groups: 4..0, 12..5, 19..13, 24..20, 31..25
    localparam logic [31:0] LESB_SIG_GRP_A   = 32'h0000_001f;
    localparam logic [31:0] LESB_SIG_GRP_B   = 32'h0000_1fe0;
    localparam logic [31:0] LESB_SIG_GRP_C   = 32'h000f_e000;
    localparam logic [31:0] LESB_SIG_GRP_D   = 32'h01f0_0000;
    localparam logic [31:0] LESB_SIG_GRP_E   = 32'hfe00_0000;

    typedef struct packed {
        logic [15:0] warn_latch;
        logic [31:0] sig_latch;
        logic [15:0] last_code;
        logic [15:0] stop_code;
        logic [31:0] rd_data;
        logic        rd_valid;
        logic        rd_error;
    } lesb_state_t;

    // error events from the detection sources
    typedef struct packed {
        logic        warn_valid;
        logic [15:0] warn_code;
        logic        stop_valid;
        logic [15:0] stop_code;
    } lesb_event_t;

endpackage

/* File: hw/lesb_bank.sv */
// Function
// RULE1: sixteen-bit warning latch, one bit per class-0 error, 1 means seen.
// RULE2: fault reset clears every warning latch bit. The code re-latches bits whose cause is present during fault reset.
// RULE3: warning bits 10, 11, 13 drop by themselves once their cause is gone.
// RULE4: warning bits 0-7: general, stage hot, motor hot, reserved, overloads, CAN.
// RULE5: warning bits 8-15: encoder, RS485, safe torque off, DC bus, fieldbus, position, reserved.
// RULE6: thirty-two-bit monitoring signal latch, 1 means activated and saved.
// RULE7: signal bits 0-4: general, limit switches, range, quick stop, safe torque off zero.
// RULE8: signal bit 5 reserved; bits 6-12 comm, frequency, mode, reserved, fieldbus.
// RULE9: signal bit 13 reserved; bits 14-19 DC bus, mains, motor, encoder.
// RULE10: signal bits 20-24: 24 V, overtemperature, deviation, velocity, safe torque off mismatch.
// RULE11: signal bits 29-31 memory, booting, system; 25 and 27 reserved. The code also treats 26 and 28 as reserved.
// RULE12: holds code of most recent class-0 error in sixteen bits.
// RULE13: class-0 code stays after error goes inactive, until fault reset.
// RULE14: class-0 code reads zero when no class-0 error recorded.
// RULE15: holds code of most recent stopping error, classes 1 to 4.
// RULE16: master reads code registers after process data reports an error.
// RULE17: all four registers read-only; writes change nothing.
// RULE18: latched bits stay set until fault reset, except self-clearing warning bits.
`timescale 1ns/10ps
`default_nettype none

module lesb_bank
    import lesb_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_fault_reset,
    input  wire logic [15:0] i_warn_cause,
    input  wire logic [31:0] i_sig_cause,
    input  wire lesb_event_t i_event,
    input  wire logic        i_rd_req,
    input  wire logic        i_wr_req,
    input  wire logic [15:0] i_addr,
    output logic [31:0]      o_rd_data,
    output logic             o_rd_valid,
    output logic             o_rd_error,
    output logic [15:0]      o_warn_latch,
    output logic [31:0]      o_sig_latch,
    output logic [15:0]      o_last_code,
    output logic [15:0]      o_stop_code
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    lesb_state_t state_reg;
    lesb_state_t state_next;

    function automatic logic [31:0] lesb_read(input lesb_state_t s, input logic [15:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            LESB_OFS_STOP_CODE:  d = {16'h0000, s.stop_code};
            LESB_OFS_SIG_LATCH:  d = s.sig_latch;
            LESB_OFS_LAST_CODE:  d = {16'h0000, s.last_code};
            LESB_OFS_WARN_LATCH: d = {16'h0000, s.warn_latch};
            default:             d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    function automatic logic lesb_mapped(input logic [15:0] a);
        return (a == LESB_OFS_STOP_CODE) || (a == LESB_OFS_SIG_LATCH) ||
               (a == LESB_OFS_LAST_CODE) || (a == LESB_OFS_WARN_LATCH);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // sticky latching; a cause present during fault reset re-latches,
        // so set wins over clear
        if (i_fault_reset) begin
            state_next.warn_latch = (i_warn_cause & ~LESB_WARN_RSVD);    // see RULE2
            state_next.sig_latch  = (i_sig_cause & ~LESB_SIG_RSVD);      // see RULE18
            state_next.last_code  = LESB_RST_CODE;                       // see RULE13
        end else begin
            state_next.warn_latch = (state_reg.warn_latch & ~LESB_WARN_AUTO)
                                  | (i_warn_cause & ~LESB_WARN_RSVD);    // see RULE1
            state_next.sig_latch  = state_reg.sig_latch
                                  | (i_sig_cause & ~LESB_SIG_RSVD);      // see RULE6
        end
        // auto bits simply follow their cause
        state_next.warn_latch = (state_next.warn_latch & ~LESB_WARN_AUTO)
                              | (i_warn_cause & LESB_WARN_AUTO);         // see RULE3
        if (i_event.warn_valid) begin
            state_next.last_code = i_event.warn_code;                    // see RULE12
        end
        if (i_event.stop_valid) begin
            state_next.stop_code = i_event.stop_code;                    // see RULE15
        end
        // writes are refused and flagged; contents untouched
        state_next.rd_valid = i_rd_req || i_wr_req;
        state_next.rd_error = i_wr_req || (i_rd_req && !lesb_mapped(i_addr));  // see RULE17
        state_next.rd_data  = i_rd_req ? lesb_read(state_reg, i_addr) : 32'h0000_0000;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg            <= '0;
            state_reg.warn_latch <= LESB_RST_WARN;
            state_reg.sig_latch  <= LESB_RST_SIG;
            state_reg.last_code  <= LESB_RST_CODE;                       // see RULE14
            state_reg.stop_code  <= LESB_RST_CODE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rd_data    = state_reg.rd_data;
    assign o_rd_valid   = state_reg.rd_valid;
    assign o_rd_error   = state_reg.rd_error;
    assign o_warn_latch = state_reg.warn_latch;
    assign o_sig_latch  = state_reg.sig_latch;
    assign o_last_code  = state_reg.last_code;
    assign o_stop_code  = state_reg.stop_code;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_warn_sticky_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE18
        (!i_fault_reset && $past(i_reset_n)) |=>
            ((o_warn_latch & ~LESB_WARN_AUTO) & $past(o_warn_latch)) == ($past(o_warn_latch) & ~LESB_WARN_AUTO))
        else $error("sticky warning bit lost");

    a_warn_cause_sets: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE1
        1'b1 |=> ((o_warn_latch & $past(i_warn_cause) & ~LESB_WARN_RSVD)
                  == ($past(i_warn_cause) & ~LESB_WARN_RSVD)))
        else $error("warning cause not latched");

    a_fault_clears: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE2
        (i_fault_reset && i_warn_cause == 16'h0000) |=> (o_warn_latch == 16'h0000))
        else $error("fault reset left warning bits");

    a_auto_follow: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE3
        1'b1 |=> ((o_warn_latch & LESB_WARN_AUTO) == ($past(i_warn_cause) & LESB_WARN_AUTO)))
        else $error("self-clearing bits wrong");

    a_sig_sticky: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE6
        (!i_fault_reset) |=> ((o_sig_latch & $past(o_sig_latch)) == $past(o_sig_latch)))
        else $error("signal latch bit lost");

    a_sig_reserved: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE9
        (o_sig_latch & LESB_SIG_RSVD) == 32'h0000_0000)
        else $error("reserved signal bit set");

    a_last_code_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE13
        (!i_event.warn_valid && !i_fault_reset) |=> $stable(o_last_code))
        else $error("class-0 code changed");

    a_last_code_load: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE12
        i_event.warn_valid |=> (o_last_code == $past(i_event.warn_code)))
        else $error("class-0 code not stored");

    a_stop_code_load: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE15
        i_event.stop_valid |=> (o_stop_code == $past(i_event.stop_code)))
        else $error("stop code not stored");

    a_write_refused: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (i_wr_req && !i_rd_req) |=> (o_rd_error && o_rd_valid))
        else $error("write not refused");

    a_read_value: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (i_rd_req && !i_wr_req && i_addr == LESB_OFS_SIG_LATCH) |=>
            (o_rd_data == $past(o_sig_latch) && !o_rd_error))
        else $error("signal latch read wrong");

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    a_warn_low_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE4
        1'b1 |=> ((o_warn_latch & $past(i_warn_cause) & LESB_WARN_GRP_LO & ~LESB_WARN_RSVD)
                  == ($past(i_warn_cause) & LESB_WARN_GRP_LO & ~LESB_WARN_RSVD)))
        else $error("low warning group not latched");

    a_warn_low_rsvd: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE4
        (o_warn_latch & LESB_WARN_RSVD & LESB_WARN_GRP_LO) == 16'h0000)
        else $error("reserved low warning bit set");

    a_warn_high_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE5
        1'b1 |=> ((o_warn_latch & $past(i_warn_cause) & LESB_WARN_GRP_HI & ~LESB_WARN_RSVD)
                  == ($past(i_warn_cause) & LESB_WARN_GRP_HI & ~LESB_WARN_RSVD)))
        else $error("high warning group not latched");

    a_warn_high_rsvd: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE5
        (o_warn_latch & LESB_WARN_RSVD & LESB_WARN_GRP_HI) == 16'h0000)
        else $error("reserved high warning bit set");

    a_sig_grpa_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE7
        1'b1 |=> ((o_sig_latch & $past(i_sig_cause) & LESB_SIG_GRP_A)
                  == ($past(i_sig_cause) & LESB_SIG_GRP_A)))
        else $error("signal group a not latched");

    a_sig_grpa_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE7
        !i_fault_reset |=> ((o_sig_latch & $past(o_sig_latch) & LESB_SIG_GRP_A)
                            == ($past(o_sig_latch) & LESB_SIG_GRP_A)))
        else $error("signal group a bit lost");

    a_sig_grpb_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE8
        1'b1 |=> ((o_sig_latch & $past(i_sig_cause) & LESB_SIG_GRP_B & ~LESB_SIG_RSVD)
                  == ($past(i_sig_cause) & LESB_SIG_GRP_B & ~LESB_SIG_RSVD)))
        else $error("signal group b not latched");

    a_sig_grpb_rsvd: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE8
        (o_sig_latch & LESB_SIG_RSVD & LESB_SIG_GRP_B) == 32'h0000_0000)
        else $error("reserved signal group b bit set");

    a_sig_grpb_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE8
        !i_fault_reset |=> ((o_sig_latch & $past(o_sig_latch) & LESB_SIG_GRP_B)
                            == ($past(o_sig_latch) & LESB_SIG_GRP_B)))
        else $error("signal group b bit lost");

    a_sig_grpc_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE9
        1'b1 |=> ((o_sig_latch & $past(i_sig_cause) & LESB_SIG_GRP_C & ~LESB_SIG_RSVD)
                  == ($past(i_sig_cause) & LESB_SIG_GRP_C & ~LESB_SIG_RSVD)))
        else $error("signal group c not latched");

    a_sig_grpc_rsvd: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE9
        (o_sig_latch & LESB_SIG_RSVD & LESB_SIG_GRP_C) == 32'h0000_0000)
        else $error("reserved signal group c bit set");

    a_sig_grpc_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE9
        !i_fault_reset |=> ((o_sig_latch & $past(o_sig_latch) & LESB_SIG_GRP_C)
                            == ($past(o_sig_latch) & LESB_SIG_GRP_C)))
        else $error("signal group c bit lost");

    a_sig_grpd_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE10
        1'b1 |=> ((o_sig_latch & $past(i_sig_cause) & LESB_SIG_GRP_D)
                  == ($past(i_sig_cause) & LESB_SIG_GRP_D)))
        else $error("signal group d not latched");

    a_sig_grpd_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE10
        !i_fault_reset |=> ((o_sig_latch & $past(o_sig_latch) & LESB_SIG_GRP_D)
                            == ($past(o_sig_latch) & LESB_SIG_GRP_D)))
        else $error("signal group d bit lost");

    a_sig_grpe_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE11
        1'b1 |=> ((o_sig_latch & $past(i_sig_cause) & LESB_SIG_GRP_E & ~LESB_SIG_RSVD)
                  == ($past(i_sig_cause) & LESB_SIG_GRP_E & ~LESB_SIG_RSVD)))
        else $error("signal group e not latched");

    a_sig_grpe_rsvd: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE11
        (o_sig_latch & LESB_SIG_RSVD & LESB_SIG_GRP_E) == 32'h0000_0000)
        else $error("reserved signal group e bit set");

    a_sig_grpe_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE11
        !i_fault_reset |=> ((o_sig_latch & $past(o_sig_latch) & LESB_SIG_GRP_E)
                            == ($past(o_sig_latch) & LESB_SIG_GRP_E)))
        else $error("signal group e bit lost");

    // ------------------------------------------------------------------
    // latch and clear
    // ------------------------------------------------------------------
    a_warn_no_spurious: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE1
        1'b1 |=> ((o_warn_latch & ~$past(o_warn_latch) & ~$past(i_warn_cause))
                  == 16'h0000))
        else $error("warning bit set without cause");

    a_sig_no_spurious: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE6
        1'b1 |=> ((o_sig_latch & ~$past(o_sig_latch) & ~$past(i_sig_cause))
                  == 32'h0000_0000))
        else $error("signal bit set without cause");

    a_warn_fault_only: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE2
        i_fault_reset |=>
            ((o_warn_latch & ~$past(i_warn_cause)) == 16'h0000))
        else $error("warning bit survived fault reset");

    a_sig_fault_only: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE18
        i_fault_reset |=>
            ((o_sig_latch & ~$past(i_sig_cause)) == 32'h0000_0000))
        else $error("signal bit survived fault reset");

    a_sig_fault_clears: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE18
        (i_fault_reset && i_sig_cause == 32'h0000_0000) |=> (o_sig_latch == 32'h0000_0000))
        else $error("fault reset left signal bits");

    a_last_code_empty: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE14
        (i_fault_reset && !i_event.warn_valid) |=>
            (o_last_code == 16'h0000))
        else $error("class-0 code not zero after clear");

    a_stop_code_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE15
        !i_event.stop_valid |=> $stable(o_stop_code))
        else $error("stop code changed without event");

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    a_read_warn: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE1
        (i_rd_req && !i_wr_req && i_addr == LESB_OFS_WARN_LATCH) |=>
            (o_rd_data == {16'h0000, $past(o_warn_latch)} && !o_rd_error))
        else $error("warning latch read wrong");

    a_read_last: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE12
        (i_rd_req && !i_wr_req && i_addr == LESB_OFS_LAST_CODE) |=>
            (o_rd_data == {16'h0000, $past(o_last_code)} && !o_rd_error))
        else $error("class-0 code read wrong");

    a_read_stop: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE15
        (i_rd_req && !i_wr_req && i_addr == LESB_OFS_STOP_CODE) |=>
            (o_rd_data == {16'h0000, $past(o_stop_code)} && !o_rd_error))
        else $error("stop code read wrong");

    a_read_unmapped: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (i_rd_req && !lesb_mapped(i_addr)) |=>
            (o_rd_error && o_rd_data == 32'h0000_0000))
        else $error("unmapped read not refused");

    a_write_no_data: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (i_wr_req && !i_rd_req) |=> (o_rd_data == 32'h0000_0000))
        else $error("write returned data");

    a_read_ok: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (i_rd_req && !i_wr_req && lesb_mapped(i_addr)) |=>
            (o_rd_valid && !o_rd_error))
        else $error("mapped read refused");

    a_idle_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (!i_rd_req && !i_wr_req) |=>
            (!o_rd_valid && !o_rd_error && o_rd_data == 32'h0000_0000))
        else $error("answer without request");

    a_error_valid: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        o_rd_error |-> o_rd_valid)
        else $error("error without valid");

    a_data_valid: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (o_rd_data != 32'h0000_0000) |-> o_rd_valid)
        else $error("data without valid");

    a_write_keeps_code: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // see RULE17
        (i_wr_req && !i_event.warn_valid && !i_fault_reset) |=>
            $stable(o_last_code))
        else $error("write changed class-0 code");

endmodule

`default_nettype wire

/* File: test/lesb_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// fieldbus master: one parameter access per call
// ------------------------------------------
module lesb_master (
    input  wire logic        i_mclk,
    input  wire logic [31:0] i_rd_data,
    input  wire logic        i_rd_valid,
    input  wire logic        i_rd_error,
    output logic             o_rd_req,
    output logic             o_wr_req,
    output logic [15:0]      o_addr
);
    initial begin
        o_rd_req = 1'b0;
        o_wr_req = 1'b0;
        o_addr   = 16'h0000;
    end

    // address inverted on release so a stale decode cannot pass for a hit
    task automatic xfer(input logic wr, input logic [15:0] a, output logic [31:0] d,
                        output logic v, output logic e);
        @(posedge i_mclk);
        o_rd_req <= ~wr;
        o_wr_req <= wr;
        o_addr   <= a;
        @(posedge i_mclk);
        o_rd_req <= 1'b0;
        o_wr_req <= 1'b0;
        o_addr   <= ~a;
        #1;
        d = i_rd_data;
        v = i_rd_valid;
        e = i_rd_error;
    endtask
endmodule
`default_nettype wire

/* File: test/test_latched_error_status_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module test_latched_error_status_bank
    import lesb_pkg::*;
;
    logic        i_mclk, i_reset_n, i_fault_reset, rd_req, wr_req, rd_valid, rd_error;
    logic [15:0] i_warn_cause, addr;
    logic [31:0] i_sig_cause, rd_data;
    lesb_event_t i_event;
    logic [15:0] mon_warn, mon_last, mon_stop;
    logic [31:0] mon_sig;
    integer      err_count, n_tests;

    lesb_bank dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_fault_reset(i_fault_reset),
        .i_warn_cause(i_warn_cause), .i_sig_cause(i_sig_cause), .i_event(i_event),
        .i_rd_req(rd_req), .i_wr_req(wr_req), .i_addr(addr), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_rd_error(rd_error), .o_warn_latch(mon_warn),
        .o_sig_latch(mon_sig), .o_last_code(mon_last), .o_stop_code(mon_stop));
    lesb_master m (.i_mclk(i_mclk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .i_rd_error(rd_error), .o_rd_req(rd_req), .o_wr_req(wr_req), .o_addr(addr));

    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    // ------------------------------------------
    // compare and access tasks
    // ------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] d;
        logic v, e;
        m.xfer(1'b0, a, d, v, e);
        check({30'h0, v, e}, {30'h0, 1'b1, ee});
        check(d, exp);
    endtask
    task automatic wr(input logic [15:0] a);
        logic [31:0] d;
        logic v, e;
        m.xfer(1'b1, a, d, v, e);
        check({d[29:0], v, e}, 32'h3);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge i_mclk);
        err_count++;
        $display("Error at %0t: watchdog ran out", $time);
        close_out;
    end

    initial begin
        {i_reset_n, i_fault_reset, i_warn_cause, i_sig_cause, i_event} = '0;
        err_count = 0;
        n_tests = 0;
        repeat (8) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        rd(LESB_OFS_STOP_CODE, 32'h0, 1'b0);
        rd(LESB_OFS_SIG_LATCH, 32'h0, 1'b0);
        rd(LESB_OFS_LAST_CODE, 32'h0, 1'b0);
        rd(LESB_OFS_WARN_LATCH, 32'h0, 1'b0);
        rd(16'h1c0c, 32'h0, 1'b1);
        $display("reset values test done");
        // one-cycle causes plus two stop events back to back
        @(posedge i_mclk);
        i_warn_cause <= 16'hffff;
        i_sig_cause  <= 32'hffff_ffff;
        i_event      <= '{1'b1, 16'h0a5c, 1'b1, 16'h7311};
        @(posedge i_mclk);
        i_warn_cause <= 16'h0000;
        i_sig_cause  <= 32'h0;
        i_event      <= '{1'b0, 16'h0000, 1'b1, 16'h7322};
        @(posedge i_mclk);
        i_event      <= '0;
        rd(LESB_OFS_WARN_LATCH, {16'h0, ~LESB_WARN_RSVD & ~LESB_WARN_AUTO}, 1'b0);
        rd(LESB_OFS_SIG_LATCH, ~LESB_SIG_RSVD, 1'b0);
        rd(LESB_OFS_LAST_CODE, 32'h0a5c, 1'b0);
        rd(LESB_OFS_STOP_CODE, 32'h7322, 1'b0);
        wr(LESB_OFS_SIG_LATCH);
        wr(LESB_OFS_LAST_CODE);
        rd(LESB_OFS_SIG_LATCH, ~LESB_SIG_RSVD, 1'b0);
        rd(LESB_OFS_LAST_CODE, 32'h0a5c, 1'b0);
        $display("latch and write test done");
        @(posedge i_mclk);
        i_warn_cause <= LESB_WARN_AUTO;
        rd(LESB_OFS_WARN_LATCH, {16'h0, ~LESB_WARN_RSVD}, 1'b0);
        @(posedge i_mclk);
        i_warn_cause  <= 16'h0000;
        i_fault_reset <= 1'b1;
        @(posedge i_mclk);
        i_fault_reset <= 1'b0;
        rd(LESB_OFS_WARN_LATCH, 32'h0, 1'b0);
        rd(LESB_OFS_SIG_LATCH, 32'h0, 1'b0);
        rd(LESB_OFS_LAST_CODE, 32'h0, 1'b0);
        rd(LESB_OFS_STOP_CODE, 32'h7322, 1'b0);
        check({16'h0, mon_warn}, 32'h0);
        check(mon_sig, 32'h0);
        check({16'h0, mon_last}, 32'h0);
        check({16'h0, mon_stop}, 32'h7322);
        $display("fault reset test done");
        // a cause still present during fault reset must stay latched
        @(posedge i_mclk);
        i_sig_cause   <= 32'h0000_0001;
        i_fault_reset <= 1'b1;
        @(posedge i_mclk);
        i_sig_cause   <= 32'h0;
        i_fault_reset <= 1'b0;
        rd(LESB_OFS_SIG_LATCH, 32'h1, 1'b0);
        check(mon_sig, 32'h1);
        $display("set wins test done");
        close_out;
    end
endmodule
`default_nettype wire
